// File: src/port_v_regs.vh
// register offsets, reset values and field positions for the shared 8-bit port
// assumes a 32-bit apb bus with word-aligned registers
// Functional notes
// - latch read returns latch if output, else pin
// - pin 1 stall detector beats everything
// - pin 1 motor driver next below stall
// - pin 1 mosi, then pwm5, then latch
// - pin 0 stall detector highest priority
// - pin 0 motor driver below stall only
// - pin 0 first timer beats second timer
// - pin 0 second timer channel 0 next
// - pin 0 scl, pwm4, miso, then latch
// - pin input register always shows pins
// - writes to pin input register ignored
// - pin input shows driven pins too
// - direction bit one output, zero input
// - pins 7,5 motor driver forces output
// - pins 6,4 motor or timer forces output
// - direction register accessible at any time
// - read value follows a pin change within four cycles
`ifndef PORT_V_REGS_VH
`define PORT_V_REGS_VH

// ==========================================================
// register offsets (byte addresses)
`define OFS_OUTPUT_LATCH 12'h000
`define OFS_PIN_INPUT 12'h004
`define OFS_DIRECTION 12'h008
`define OFS_ALT_CTRL 12'h00C

// ==========================================================
// reset values
`define RST_OUTPUT_LATCH 8'h00
`define RST_DIRECTION 8'h00

// ==========================================================
// field positions
`define PIN_0 0
`define PIN_1 1
`define SYNC_STAGES 3

`endif

// File: src/pin_sync.v
// three-stage input synchroniser for a bus of pins
// assumes the pins are asynchronous to CLK_IN; output moves once stages two and three agree
`timescale 1ns/10ps
`default_nettype none

module pin_sync #(
	parameter WIDTH = 8
) (
	input wire clk_in,
	input wire rst_in,
	input wire [WIDTH-1:0] async_in,
	output reg [WIDTH-1:0] level_out
);

	reg [WIDTH-1:0] s1_r;
	reg [WIDTH-1:0] s2_r;
	reg [WIDTH-1:0] s3_r;
	integer i;

	always @(posedge clk_in) begin
		if (rst_in) begin
			s1_r <= {WIDTH{1'b0}};
			s2_r <= {WIDTH{1'b0}};
			s3_r <= {WIDTH{1'b0}};
			level_out <= {WIDTH{1'b0}};
		end else begin
			s1_r <= async_in;
			s2_r <= s1_r;
			s3_r <= s2_r;
			// a change counts only when the two later stages agree
			for (i = 0; i < WIDTH; i = i + 1) begin
				if (s2_r[i] == s3_r[i]) begin
					level_out[i] <= s3_r[i];
				end
			end
		end
	end

endmodule // pin_sync

`default_nettype wire

// File: src/port_v_pins.v
// pin mux, direction and apb register file for the shared 8-bit port
// assumes peripheral request/data inputs are on CLK_IN; pins arrive asynchronously
`timescale 1ns/10ps
`default_nettype none
`include "port_v_regs.vh"

module port_v_pins #(
	parameter WIDTH = 8
) (
	// clock and reset
	input wire CLK_IN,
	input wire RST_IN,
	// apb slave
	input wire PSEL_IN,
	input wire PENABLE_IN,
	input wire PWRITE_IN,
	input wire [11:0] PADDR_IN,
	input wire [31:0] PWDATA_IN,
	input wire [3:0] PSTRB_IN,
	output reg [31:0] PRDATA_OUT,
	output reg PREADY_OUT,
	output reg PSLVERR_OUT,
	// stall detector requests and data, pins 1 and 0
	input wire [1:0] STALL_EN_IN,
	input wire [1:0] STALL_DAT_IN,
	// motor pwm driver, one enable and data per pin
	input wire [7:0] MOTOR_EN_IN,
	input wire [7:0] MOTOR_DAT_IN,
	// timers: first unit on pin 0, second unit channels 0,2,3 on pins 0,4,6
	input wire TIMER0_OC_EN_IN,
	input wire TIMER0_OC_DAT_IN,
	input wire [3:0] TIMER1_OC_EN_IN,
	input wire [3:0] TIMER1_OC_DAT_IN,
	// spi: mosi on pin 1, miso on pin 0
	input wire SPI_MOSI_EN_IN,
	input wire SPI_MOSI_DAT_IN,
	input wire SPI_MISO_EN_IN,
	input wire SPI_MISO_DAT_IN,
	// pwm channels 5 and 4
	input wire PWM5_EN_IN,
	input wire PWM5_DAT_IN,
	input wire PWM4_EN_IN,
	input wire PWM4_DAT_IN,
	// iic scl on pin 0, open drain
	input wire IIC_SCL_EN_IN,
	input wire IIC_SCL_DAT_IN,
	// pads
	input wire [WIDTH-1:0] PIN_IN,
	output reg [WIDTH-1:0] PIN_OUT,
	output reg [WIDTH-1:0] PIN_OE_OUT,
	// buffered pin level, for peripheral inputs
	output reg [WIDTH-1:0] PIN_LEVEL_OUT
);

	// ==========================================================
	// state
	reg [WIDTH-1:0] latch_r;
	reg [WIDTH-1:0] dir_r;
	reg [WIDTH-1:0] pin_out_nxt;
	reg [WIDTH-1:0] pin_oe_nxt;
	reg [31:0] rdata_nxt;
	reg hit_nxt;
	wire [WIDTH-1:0] pin_sync_w;
	wire setup_w;
	wire wr_w;

	// ==========================================================
	// pin input synchroniser
	pin_sync #(
		.WIDTH(WIDTH)
	) u_sync (
		.clk_in(CLK_IN),
		.rst_in(RST_IN),
		.async_in(PIN_IN),
		.level_out(pin_sync_w)
	);

	// ==========================================================
	// pin mux
	always @* begin
		// default: plain gpio, direction bit decides
		pin_out_nxt = latch_r;
		pin_oe_nxt = dir_r;
		// pin 1 priority chain, lowest first so later wins
		if (PWM5_EN_IN) begin
			pin_out_nxt[`PIN_1] = PWM5_DAT_IN;
			pin_oe_nxt[`PIN_1] = 1'b1;
		end
		if (SPI_MOSI_EN_IN) begin
			pin_out_nxt[`PIN_1] = SPI_MOSI_DAT_IN;
			pin_oe_nxt[`PIN_1] = 1'b1;
		end
		if (MOTOR_EN_IN[`PIN_1]) begin
			pin_out_nxt[`PIN_1] = MOTOR_DAT_IN[`PIN_1];
			pin_oe_nxt[`PIN_1] = 1'b1;
		end
		if (STALL_EN_IN[`PIN_1]) begin
			pin_out_nxt[`PIN_1] = STALL_DAT_IN[`PIN_1];
			pin_oe_nxt[`PIN_1] = 1'b1;
		end
		// pin 0 priority chain
		if (SPI_MISO_EN_IN) begin
			pin_out_nxt[`PIN_0] = SPI_MISO_DAT_IN;
			pin_oe_nxt[`PIN_0] = 1'b1;
		end
		if (PWM4_EN_IN) begin
			pin_out_nxt[`PIN_0] = PWM4_DAT_IN;
			pin_oe_nxt[`PIN_0] = 1'b1;
		end
		if (IIC_SCL_EN_IN) begin
			// open drain: drive low only, release for high
			pin_out_nxt[`PIN_0] = 1'b0;
			pin_oe_nxt[`PIN_0] = ~IIC_SCL_DAT_IN;
		end
		if (TIMER1_OC_EN_IN[0]) begin
			pin_out_nxt[`PIN_0] = TIMER1_OC_DAT_IN[0];
			pin_oe_nxt[`PIN_0] = 1'b1;
		end
		if (TIMER0_OC_EN_IN) begin
			pin_out_nxt[`PIN_0] = TIMER0_OC_DAT_IN;
			pin_oe_nxt[`PIN_0] = 1'b1;
		end
		if (MOTOR_EN_IN[`PIN_0]) begin
			pin_out_nxt[`PIN_0] = MOTOR_DAT_IN[`PIN_0];
			pin_oe_nxt[`PIN_0] = 1'b1;
		end
		if (STALL_EN_IN[`PIN_0]) begin
			pin_out_nxt[`PIN_0] = STALL_DAT_IN[`PIN_0];
			pin_oe_nxt[`PIN_0] = 1'b1;
		end
		// upper pins: motor forces output on 7,5; motor or timer on 6,4
		if (MOTOR_EN_IN[7]) begin
			pin_out_nxt[7] = MOTOR_DAT_IN[7];
			pin_oe_nxt[7] = 1'b1;
		end
		if (MOTOR_EN_IN[5]) begin
			pin_out_nxt[5] = MOTOR_DAT_IN[5];
			pin_oe_nxt[5] = 1'b1;
		end
		if (MOTOR_EN_IN[6]) begin
			pin_out_nxt[6] = MOTOR_DAT_IN[6];
			pin_oe_nxt[6] = 1'b1;
		end else if (TIMER1_OC_EN_IN[3]) begin
			pin_out_nxt[6] = TIMER1_OC_DAT_IN[3];
			pin_oe_nxt[6] = 1'b1;
		end
		if (MOTOR_EN_IN[4]) begin
			pin_out_nxt[4] = MOTOR_DAT_IN[4];
			pin_oe_nxt[4] = 1'b1;
		end else if (TIMER1_OC_EN_IN[2]) begin
			pin_out_nxt[4] = TIMER1_OC_DAT_IN[2];
			pin_oe_nxt[4] = 1'b1;
		end
		// motor enables on pins 3 and 2 have no mux here; leave them to gpio
	end

	// registered pad drive keeps outputs glitch free; costs one cycle of latency
	always @(posedge CLK_IN) begin
		if (RST_IN) begin
			PIN_OUT <= {WIDTH{1'b0}};
			PIN_OE_OUT <= {WIDTH{1'b0}};
			PIN_LEVEL_OUT <= {WIDTH{1'b0}};
		end else begin
			PIN_OUT <= pin_out_nxt;
			PIN_OE_OUT <= pin_oe_nxt;
			PIN_LEVEL_OUT <= pin_sync_w;
		end
	end

	// ==========================================================
	// apb register file
	assign setup_w = PSEL_IN & ~PENABLE_IN;
	assign wr_w = PSEL_IN & PENABLE_IN & PREADY_OUT & PWRITE_IN;

	always @* begin
		rdata_nxt = 32'h00000000;
		hit_nxt = 1'b1;
		case (PADDR_IN)
			`OFS_OUTPUT_LATCH: begin
				// output bits show the latch, input bits the pin
				rdata_nxt[WIDTH-1:0] = (dir_r & latch_r) | (~dir_r & pin_sync_w);
			end
			`OFS_PIN_INPUT: begin
				rdata_nxt[WIDTH-1:0] = pin_sync_w;
			end
			`OFS_DIRECTION: begin
				rdata_nxt[WIDTH-1:0] = dir_r;
			end
			default: begin
				hit_nxt = 1'b0;
			end
		endcase
	end

	// no wait states: pready rises the cycle after setup
	always @(posedge CLK_IN) begin
		if (RST_IN) begin
			latch_r <= `RST_OUTPUT_LATCH;
			dir_r <= `RST_DIRECTION;
			PRDATA_OUT <= 32'h00000000;
			PREADY_OUT <= 1'b0;
			PSLVERR_OUT <= 1'b0;
		end else begin
			PREADY_OUT <= setup_w;
			if (setup_w) begin
				PRDATA_OUT <= PWRITE_IN ? 32'h00000000 : rdata_nxt;
				PSLVERR_OUT <= ~hit_nxt;
			end else begin
				PSLVERR_OUT <= 1'b0;
			end
			if (wr_w && PSTRB_IN[0]) begin
				case (PADDR_IN)
					`OFS_OUTPUT_LATCH: begin
						latch_r <= PWDATA_IN[WIDTH-1:0];
					end
					`OFS_DIRECTION: begin
						dir_r <= PWDATA_IN[WIDTH-1:0];
					end
					default: begin
						// pin input register is read only: write dropped
						latch_r <= latch_r;
					end
				endcase
			end
		end
	end

endmodule // port_v_pins

`default_nettype wire

// File: bench/pad_model.sv
// pad model: a pin shows what the port drives, else the outside level
// assumes ext_in is the far-side source, changed by the bench
`timescale 1ns/10ps
`default_nettype none
module pad_model (
	// drive from the port
	input wire logic [7:0] drv_in,
	input wire logic [7:0] oe_in,
	// far side
	input wire logic [7:0] ext_in,
	output logic [7:0] pad_out
);
	// a driven pin reads back its own drive, the level the port sees
	assign pad_out = (oe_in & drv_in) | (~oe_in & ext_in);
endmodule // pad_model
`default_nettype wire

// File: bench/port_v_monitor.sv
// checks on pin priority, forced direction and apb answer
// assumes it is bound to port_v_pins
`timescale 1ns/10ps
`default_nettype none
module port_v_monitor #(
	parameter WIDTH = 8
) (
	// clock, reset, apb
	input wire logic CLK_IN,
	input wire logic RST_IN,
	input wire logic PSEL_IN,
	input wire logic PENABLE_IN,
	input wire logic PREADY_OUT,
	// sources
	input wire logic [1:0] STALL_EN_IN,
	input wire logic [1:0] STALL_DAT_IN,
	input wire logic [7:0] MOTOR_EN_IN,
	input wire logic [7:0] MOTOR_DAT_IN,
	input wire logic [3:0] TIMER1_OC_EN_IN,
	// pads
	input wire logic [WIDTH-1:0] PIN_OUT,
	input wire logic [WIDTH-1:0] PIN_OE_OUT
);
	default clocking @(posedge CLK_IN); endclocking
	default disable iff (RST_IN);
	// ========
	// checks
	sequence s_setup; PSEL_IN && !PENABLE_IN; endsequence
	property p_rdy; s_setup |=> PREADY_OUT; endproperty
	a_rdy: assert property (p_rdy) else $error("late ready");
	property p_s1; STALL_EN_IN[1] |=> PIN_OE_OUT[1] && PIN_OUT[1] == $past(STALL_DAT_IN[1]); endproperty
	a_s1: assert property (p_s1) else $error("pin1 stall");
	property p_s0; STALL_EN_IN[0] |=> PIN_OE_OUT[0] && PIN_OUT[0] == $past(STALL_DAT_IN[0]); endproperty
	a_s0: assert property (p_s0) else $error("pin0 stall");
	property p_m1; !STALL_EN_IN[1] && MOTOR_EN_IN[1] |=> PIN_OUT[1] == $past(MOTOR_DAT_IN[1]); endproperty
	a_m1: assert property (p_m1) else $error("pin1 motor");
	property p_m0; !STALL_EN_IN[0] && MOTOR_EN_IN[0] |=> PIN_OUT[0] == $past(MOTOR_DAT_IN[0]); endproperty
	a_m0: assert property (p_m0) else $error("pin0 motor");
	property p_f7; MOTOR_EN_IN[7] |=> PIN_OE_OUT[7]; endproperty
	a_f7: assert property (p_f7) else $error("pin7 oe");
	property p_f6; MOTOR_EN_IN[6] || TIMER1_OC_EN_IN[3] |=> PIN_OE_OUT[6]; endproperty
	a_f6: assert property (p_f6) else $error("pin6 oe");
	property p_f4; MOTOR_EN_IN[4] || TIMER1_OC_EN_IN[2] |=> PIN_OE_OUT[4]; endproperty
	a_f4: assert property (p_f4) else $error("pin4 oe");
endmodule // port_v_monitor
bind port_v_pins port_v_monitor #(.WIDTH(WIDTH)) port_v_monitor_inst (.CLK_IN(CLK_IN),
	.RST_IN(RST_IN), .PSEL_IN(PSEL_IN), .PENABLE_IN(PENABLE_IN), .PREADY_OUT(PREADY_OUT),
	.STALL_EN_IN(STALL_EN_IN), .STALL_DAT_IN(STALL_DAT_IN), .MOTOR_EN_IN(MOTOR_EN_IN),
	.MOTOR_DAT_IN(MOTOR_DAT_IN), .TIMER1_OC_EN_IN(TIMER1_OC_EN_IN), .PIN_OUT(PIN_OUT),
	.PIN_OE_OUT(PIN_OE_OUT));
`default_nettype wire

// File: bench/testbench.sv
// bench for port_v_pins: apb register traffic and pin priority
// assumes a pad model on the far side
`timescale 1ns/10ps
`default_nettype none
`include "port_v_regs.vh"
module testbench;
	logic clk, rst, psel, penable, pwrite, pready, pslverr, err;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata, rd;
	logic [19:0] en_v, dat_v;
	logic [7:0] ext, pin_out, pin_oe, lvl, pad, dir, lat;
	logic [1:0] e1, e0;
	integer error_cnt = 0, num_checks = 0, seed = 32'h6184, i, n;
	port_v_pins port_v_pins_inst (.CLK_IN(clk), .RST_IN(rst), .PSEL_IN(psel),
		.PENABLE_IN(penable), .PWRITE_IN(pwrite), .PADDR_IN(paddr), .PWDATA_IN(pwdata),
		.PSTRB_IN(4'hF), .PRDATA_OUT(prdata), .PREADY_OUT(pready), .PSLVERR_OUT(pslverr),
		.STALL_EN_IN(en_v[1:0]), .STALL_DAT_IN(dat_v[1:0]), .MOTOR_EN_IN(en_v[9:2]),
		.MOTOR_DAT_IN(dat_v[9:2]), .TIMER0_OC_EN_IN(en_v[10]), .TIMER0_OC_DAT_IN(dat_v[10]),
		.TIMER1_OC_EN_IN(en_v[14:11]), .TIMER1_OC_DAT_IN(dat_v[14:11]),
		.SPI_MOSI_EN_IN(en_v[15]), .SPI_MOSI_DAT_IN(dat_v[15]), .SPI_MISO_EN_IN(en_v[16]),
		.SPI_MISO_DAT_IN(dat_v[16]), .PWM5_EN_IN(en_v[17]), .PWM5_DAT_IN(dat_v[17]),
		.PWM4_EN_IN(en_v[18]), .PWM4_DAT_IN(dat_v[18]), .IIC_SCL_EN_IN(en_v[19]),
		.IIC_SCL_DAT_IN(dat_v[19]), .PIN_IN(pad), .PIN_OUT(pin_out), .PIN_OE_OUT(pin_oe),
		.PIN_LEVEL_OUT(lvl));
	pad_model pad_model_inst (.drv_in(pin_out), .oe_in(pin_oe), .ext_in(ext), .pad_out(pad));
	// ========
	// expectations: {oe, out} per pin, highest priority first
	function logic [1:0] win1;
		win1 = en_v[1] ? {1'b1, dat_v[1]} : en_v[3] ? {1'b1, dat_v[3]} :
			en_v[15] ? {1'b1, dat_v[15]} : en_v[17] ? {1'b1, dat_v[17]} : {dir[1], lat[1]};
	endfunction
	function logic [1:0] win0;
		win0 = en_v[0] ? {1'b1, dat_v[0]} : en_v[2] ? {1'b1, dat_v[2]} :
			en_v[10] ? {1'b1, dat_v[10]} : en_v[11] ? {1'b1, dat_v[11]} :
			en_v[19] ? {~dat_v[19], 1'b0} : en_v[18] ? {1'b1, dat_v[18]} :
			en_v[16] ? {1'b1, dat_v[16]} : {dir[0], lat[0]};
	endfunction
	// pad level with no alternate function active
	function logic [7:0] mix;
		mix = (dir & lat) | (~dir & ext);
	endfunction
	task chk(input string nm, input logic [31:0] ex, input logic [31:0] got);
		num_checks++;
		if (got !== ex) begin
			error_cnt++;
			$display("MISMATCH %s exp %h got %h", nm, ex, got);
		end
	endtask
	task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		n = 0;
		@(posedge clk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clk);
		penable <= 1'b1;
		do begin
			@(posedge clk);
			n++;
		end while (pready !== 1'b1 && n < 20);
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		if (n >= 20) error_cnt++;
	endtask
	task test_done;
		if (error_cnt == 0 && num_checks > 0) $display("No errors found");
		else $display("Errors were found");
		$finish;
	endtask
	initial begin
		clk = 0;
		forever #12.5 clk = ~clk;
	end
	initial begin
		#200000;
		error_cnt++;
		test_done;
	end
	initial begin
		{psel, penable, pwrite, paddr, pwdata, en_v, dat_v, ext} = '0;
		rst = 1;
		repeat (6) @(posedge clk);
		rst <= 0;
		apb(0, `OFS_DIRECTION, 0);
		chk("dir reset", `RST_DIRECTION, rd);
		apb(0, `OFS_ALT_CTRL, 0);
		chk("unmapped err", 1, err);
		for (i = 0; i < 12; i++) begin
			dir = i == 0 ? 8'hFF : $random(seed);
			lat = $random(seed);
			ext <= $random(seed);
			apb(1, `OFS_DIRECTION, dir);
			apb(1, `OFS_OUTPUT_LATCH, lat);
			apb(1, `OFS_PIN_INPUT, ~lat);
			repeat (8) @(posedge clk);
			chk("oe", dir, pin_oe);
			chk("level", mix(), lvl);
			apb(0, `OFS_OUTPUT_LATCH, 0);
			chk("latch rd", mix(), rd);
			apb(0, `OFS_PIN_INPUT, 0);
			chk("pin rd", mix(), rd);
			apb(0, `OFS_DIRECTION, 0);
			chk("dir rd", dir, rd);
		end
		for (i = 0; i < 60; i++) begin
			en_v <= $random(seed) & $random(seed) & $random(seed);
			dat_v <= $random(seed);
			repeat (2) @(posedge clk);
			e1 = win1();
			e0 = win0();
			chk("pin1", e1 & {1'b1, e1[1]}, {pin_oe[1], pin_oe[1] & pin_out[1]});
			chk("pin0", e0 & {1'b1, e0[1]}, {pin_oe[0], pin_oe[0] & pin_out[0]});
			chk("oe hi", {en_v[9] | dir[7], en_v[8] | en_v[14] | dir[6], en_v[7] | dir[5],
				en_v[6] | en_v[13] | dir[4], dir[3:2]}, pin_oe[7:2]);
			chk("out hi", {en_v[9] ? dat_v[9] : lat[7], en_v[8] ? dat_v[8] : en_v[14] ? dat_v[14] :
				lat[6], en_v[7] ? dat_v[7] : lat[5], en_v[6] ? dat_v[6] : en_v[13] ? dat_v[13] :
				lat[4]}, pin_out[7:4]);
		end
		test_done;
	end
endmodule // testbench
`default_nettype wire
